//--- design/ppn_ctrl.sv
// Module: partition priority, regulation gating and identifier narrowing
`timescale 1ns/10ps

module ppn_ctrl #(
	parameter bit HAS_NARROW = 1'b1,
	parameter bit HAS_INT_PRI = 1'b1,
	parameter bit HAS_DN_PRI = 1'b1,
	parameter bit HAS_VENDOR = 1'b0,
	parameter bit VENDOR_CTLS = 1'b0,
	parameter bit VENDOR_MONS = 1'b0,
	parameter int FRAC_IMPL = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ppn_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ppn_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [ppn_pkg::DATA_W-1:0] rdata_o,
	input wire ppn_pkg::ppn_req_t req_a_i,
	input wire ppn_pkg::ppn_req_t req_b_i,
	output ppn_pkg::ppn_dn_t dn_o,
	output logic [ppn_pkg::PRI_W-1:0] int_pri_o,
	output logic grant_b_o,
	output logic stride_active_o,
	input wire ppn_pkg::ppn_rsp_t rsp_dn_i,
	output ppn_pkg::ppn_rsp_t rsp_up_o
);
	import ppn_pkg::*;

	localparam int SPACES = 2;
	localparam logic [FRAC_W-1:0] FRAC_MASK =
		~((16'h0001 << (FRAC_W - FRAC_IMPL)) - 16'h0001);
	// Writable selector bits: id, space and internal flag
	localparam logic [DATA_W-1:0] SEL_MASK =
		(DATA_W'(1) << SEL_INTERNAL_BIT) | (DATA_W'(1) << SEL_NS_BIT) |
		((DATA_W'(1) << REQ_ID_W) - DATA_W'(1));

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	ppn_cfg_t cfg_ff [SPACES][NUM_INT];
	logic [INT_ID_W:0] map_ff [SPACES][NUM_REQ];
	logic [DATA_W-1:0] sel_ff;
	logic [3:0] esr_ff;
	logic [DATA_W-1:0] rdata_ff;
	ppn_dn_t dn_ff;
	ppn_rsp_t rsp_ff;
	logic [PRI_W-1:0] int_pri_ff;
	logic grant_b_ff;
	logic stride_ff;

	logic sel_ns;
	logic sel_int;
	logic [REQ_ID_W-1:0] sel_id;
	logic sel_ok;
	logic map_ok;
	logic [INT_ID_W-1:0] cfg_idx;
	logic [INT_ID_W:0] map_a;
	logic [INT_ID_W:0] map_b;
	logic [INT_ID_W-1:0] id_a;
	logic [INT_ID_W-1:0] id_b;
	logic bad_a;
	ppn_cfg_t cfg_a;
	ppn_cfg_t cfg_b;
	ppn_pref_t pref_a;
	ppn_pref_t pref_b;
	logic pick_b;

	assign sel_ns = sel_ff[SEL_NS_BIT];
	assign sel_int = sel_ff[SEL_INTERNAL_BIT];
	assign sel_id = sel_ff[REQ_ID_W-1:0];

	// Selector meaning depends on narrowing
	always_comb begin
		if (HAS_NARROW) begin
			sel_ok = sel_int && (sel_id < REQ_ID_W'(NUM_INT));
			cfg_idx = sel_id[INT_ID_W-1:0];
		end else begin
			sel_ok = !sel_int && (sel_id < REQ_ID_W'(NUM_INT));
			cfg_idx = sel_id[INT_ID_W-1:0];
		end
		map_ok = HAS_NARROW && !sel_int;
	end

	// ------------------------------------------------------------
	// Request path: narrowing and preference
	// ------------------------------------------------------------
	function automatic ppn_pref_t pref_of(input ppn_cfg_t c,
		input logic [FRAC_W-1:0] u);
		if (u < c.bw_min)
			pref_of = PREF_HIGH;
		else if (u < c.bw_max)
			pref_of = PREF_MED;
		else if (c.hard_limit)
			pref_of = PREF_NONE;
		else
			pref_of = PREF_LOW;
	endfunction

	always_comb begin
		map_a = map_ff[req_a_i.ns][req_a_i.id];
		map_b = map_ff[req_b_i.ns][req_b_i.id];
		// Translate within the request's own space
		id_a = HAS_NARROW ? map_a[INT_ID_W-1:0] :
			req_a_i.id[INT_ID_W-1:0];
		id_b = HAS_NARROW ? map_b[INT_ID_W-1:0] :
			req_b_i.id[INT_ID_W-1:0];
		bad_a = HAS_NARROW ? !map_a[INT_ID_W] :
			(req_a_i.id >= REQ_ID_W'(NUM_INT));
		cfg_a = cfg_ff[req_a_i.ns][id_a];
		cfg_b = cfg_ff[req_b_i.ns][id_b];
		// Min and max limits and hard limit apply; stride does not
		pref_a = pref_of(cfg_a, req_a_i.usage);
		pref_b = pref_of(cfg_b, req_b_i.usage);
		if (!req_a_i.valid)
			pick_b = req_b_i.valid;
		else if (!req_b_i.valid)
			pick_b = 1'b0;
		else if (pref_b != pref_a)
			pick_b = pref_b > pref_a;
		else if (HAS_INT_PRI)
			pick_b = cfg_b.int_pri > cfg_a.int_pri;
		else
			pick_b = req_b_i.pri > req_a_i.pri;
	end

	// Arbitration result and internal priority
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grant_b_ff <= 1'b0;
			int_pri_ff <= RST_PRI;
			stride_ff <= 1'b0;
		end else begin
			grant_b_ff <= pick_b;
			int_pri_ff <= pick_b ?
				(HAS_INT_PRI ? cfg_b.int_pri : req_b_i.pri) :
				(HAS_INT_PRI ? cfg_a.int_pri : req_a_i.pri);
			// Only the enable bit turns stride on
			stride_ff <= pick_b ? cfg_b.stride_en : cfg_a.stride_en;
		end
	end

	// Downstream request carries original request id
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dn_ff <= '0;
		end else begin
			dn_ff.valid <= req_a_i.valid && !bad_a &&
				pref_a != PREF_NONE;
			dn_ff.ns <= req_a_i.ns;
			dn_ff.id <= req_a_i.id;
			dn_ff.pri <= HAS_DN_PRI ? cfg_a.dn_pri :
				req_a_i.pri;
		end
	end

	// Responses pass through untouched
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rsp_ff <= '0;
		else
			rsp_ff <= rsp_dn_i;
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sel_ff <= '0;
		else if (wr_i && addr_i == OFS_PART_SEL)
			sel_ff <= wdata_i & SEL_MASK;
	end

	// Mapping table, entry zero resets to internal zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < SPACES; s++)
				map_ff[s][0] <= {1'b1, DEFAULT_ID};
		end else if (wr_i && addr_i == OFS_NARROW_MAP && map_ok) begin
			map_ff[sel_ns][sel_id] <= {wdata_i[MAP_VALID_BIT],
				wdata_i[INT_ID_W-1:0]};
		end
	end

	// Settings: only the default partition resets
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int s = 0; s < SPACES; s++) begin
				cfg_ff[s][DEFAULT_ID].bw_max <= RST_FRAC & FRAC_MASK;
				cfg_ff[s][DEFAULT_ID].bw_min <= RST_FRAC & FRAC_MASK;
				cfg_ff[s][DEFAULT_ID].hard_limit <= 1'b0;
				cfg_ff[s][DEFAULT_ID].stride_en <= 1'b0;
				cfg_ff[s][DEFAULT_ID].stride_minus_one <= '0;
				cfg_ff[s][DEFAULT_ID].int_pri <= RST_PRI;
				cfg_ff[s][DEFAULT_ID].dn_pri <= RST_PRI;
			end
		end else if (wr_i && sel_ok) begin
			unique case (addr_i)
				OFS_BW_MAX: begin
					cfg_ff[sel_ns][cfg_idx].bw_max <=
						wdata_i[FRAC_W-1:0] & FRAC_MASK;
					cfg_ff[sel_ns][cfg_idx].hard_limit <=
						wdata_i[HARD_LIMIT_BIT];
				end
				OFS_BW_MIN: begin
					cfg_ff[sel_ns][cfg_idx].bw_min <=
						wdata_i[FRAC_W-1:0] & FRAC_MASK;
				end
				OFS_BW_STRIDE: begin
					cfg_ff[sel_ns][cfg_idx].stride_minus_one <=
						wdata_i[STRIDE_W-1:0];
					cfg_ff[sel_ns][cfg_idx].stride_en <=
						wdata_i[STRIDE_EN_BIT];
				end
				OFS_PRI: begin
					// Each priority kind exists on its own
					if (HAS_INT_PRI)
						cfg_ff[sel_ns][cfg_idx].int_pri <=
							wdata_i[PRI_W-1:0];
					if (HAS_DN_PRI)
						cfg_ff[sel_ns][cfg_idx].dn_pri <=
							wdata_i[PRI_DN_LSB +: PRI_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Error status: bad mapping or bad selector, write clears
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			esr_ff <= ERR_NONE;
		else if (req_a_i.valid && bad_a)
			esr_ff <= ERR_BAD_MAP;
		else if ((wr_i || rd_i) && !sel_ok && addr_i >= OFS_BW_MAX)
			esr_ff <= ERR_BAD_SEL;
		else if (wr_i && addr_i == OFS_ERROR_STATUS)
			esr_ff <= ERR_NONE;
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= '0;
		end else if (rd_i) begin
			rdata_ff <= '0;
			unique case (addr_i)
				OFS_FEATURE_ID: begin
					rdata_ff[FID_NARROW_BIT] <= HAS_NARROW;
					rdata_ff[FID_INTPRI_BIT] <= HAS_INT_PRI;
					rdata_ff[FID_DNPRI_BIT] <= HAS_DN_PRI;
					rdata_ff[FID_VENDOR_BIT] <= HAS_VENDOR;
					rdata_ff[FID_NO_VCTL_BIT] <=
						!(HAS_VENDOR && VENDOR_CTLS);
					rdata_ff[FID_NO_VMON_BIT] <=
						!(HAS_VENDOR && VENDOR_MONS);
				end
				OFS_ERROR_STATUS: rdata_ff[ESR_CODE_LSB +: 4] <= esr_ff;
				OFS_PART_SEL: rdata_ff <= sel_ff;
				OFS_NARROW_MAP: if (map_ok) begin
					rdata_ff[MAP_VALID_BIT] <=
						map_ff[sel_ns][sel_id][INT_ID_W];
					rdata_ff[INT_ID_W-1:0] <=
						map_ff[sel_ns][sel_id][INT_ID_W-1:0];
				end
				OFS_BW_MAX: if (sel_ok) begin
					rdata_ff[FRAC_W-1:0] <= cfg_ff[sel_ns][cfg_idx].bw_max;
					rdata_ff[HARD_LIMIT_BIT] <=
						cfg_ff[sel_ns][cfg_idx].hard_limit;
				end
				OFS_BW_MIN: if (sel_ok)
					rdata_ff[FRAC_W-1:0] <= cfg_ff[sel_ns][cfg_idx].bw_min;
				OFS_BW_STRIDE: if (sel_ok) begin
					rdata_ff[STRIDE_W-1:0] <=
						cfg_ff[sel_ns][cfg_idx].stride_minus_one;
					rdata_ff[STRIDE_EN_BIT] <=
						cfg_ff[sel_ns][cfg_idx].stride_en;
				end
				OFS_PRI: if (sel_ok) begin
					rdata_ff[PRI_W-1:0] <= cfg_ff[sel_ns][cfg_idx].int_pri;
					rdata_ff[PRI_DN_LSB +: PRI_W] <=
						cfg_ff[sel_ns][cfg_idx].dn_pri;
				end
				default: begin
				end
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata_o = rdata_ff;
	assign dn_o = dn_ff;
	assign rsp_up_o = rsp_ff;
	assign int_pri_o = int_pri_ff;
	assign grant_b_o = grant_b_ff;
	assign stride_active_o = stride_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_rsp_passthru: assert property (
		rsp_up_o == $past(rsp_dn_i))
		else $error("response priority altered");
	chk_dn_pri_cfg: assert property (
		HAS_DN_PRI && req_a_i.valid |=> dn_o.pri == $past(cfg_a.dn_pri))
		else $error("downstream priority not from config");
	chk_dn_pri_copy: assert property (
		!HAS_DN_PRI && req_a_i.valid |=> dn_o.pri == $past(req_a_i.pri))
		else $error("downstream priority not copied");
	chk_dn_req_id: assert property (
		req_a_i.valid |=> dn_o.id == $past(req_a_i.id))
		else $error("internal id leaked downstream");
	chk_stride_gate: assert property (
		req_a_i.valid && !req_b_i.valid
		|=> stride_active_o == $past(cfg_a.stride_en))
		else $error("stride gating wrong");
	chk_int_pri_use: assert property (
		HAS_INT_PRI && req_a_i.valid && !req_b_i.valid
		|=> int_pri_o == $past(cfg_a.int_pri))
		else $error("internal priority not from config");
	chk_bad_map_err: assert property (
		req_a_i.valid && bad_a |=> esr_ff == ERR_BAD_MAP)
		else $error("bad mapping not recorded");
	chk_hard_block: assert property (
		req_a_i.valid && cfg_a.hard_limit && req_a_i.usage >= cfg_a.bw_max
		&& req_a_i.usage >= cfg_a.bw_min |=> !dn_o.valid)
		else $error("hard limit not enforced");

	// Map write followed at once by a read of the same entry
	sequence seq_map_wr;
		wr_i && addr_i == OFS_NARROW_MAP && map_ok;
	endsequence
	sequence seq_map_rd;
		rd_i && addr_i == OFS_NARROW_MAP && map_ok && $stable(sel_ff);
	endsequence
	chk_map_readback: assert property (
		seq_map_wr ##1 seq_map_rd
		|=> rdata_o[INT_ID_W-1:0] == $past(wdata_i[INT_ID_W-1:0], 2)
		&& rdata_o[MAP_VALID_BIT] == $past(wdata_i[MAP_VALID_BIT], 2))
		else $error("mapping readback wrong");
	chk_frac_low_zero: assert property (
		rd_i && (addr_i == OFS_BW_MAX || addr_i == OFS_BW_MIN)
		|=> (rdata_o[FRAC_W-1:0] & ~FRAC_MASK) == '0)
		else $error("dropped fraction bits not zero");

endmodule // ppn_ctrl

//--- design/ppn_pkg.sv
// Package: register map, field layouts and types of the partition control block
package ppn_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int REQ_ID_W = 4;
	localparam int INT_ID_W = 2;
	localparam int NUM_REQ = 16;
	localparam int NUM_INT = 4;
	localparam int PRI_W = 4;
	localparam int FRAC_W = 16;
	localparam int STRIDE_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_FEATURE_ID = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_VENDOR_FEAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ERROR_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PART_SEL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_NARROW_MAP = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_BW_MAX = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_BW_MIN = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_BW_STRIDE = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_PRI = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SEL_NS_BIT = 16;
	localparam int SEL_INTERNAL_BIT = 17;
	localparam int MAP_VALID_BIT = 31;
	localparam int HARD_LIMIT_BIT = 31;
	localparam int STRIDE_EN_BIT = 31;
	localparam int PRI_DN_LSB = 8;
	localparam int ESR_CODE_LSB = 24;
	localparam int FID_NARROW_BIT = 0;
	localparam int FID_INTPRI_BIT = 1;
	localparam int FID_DNPRI_BIT = 2;
	localparam int FID_VENDOR_BIT = 3;
	localparam int FID_NO_VCTL_BIT = 4;
	localparam int FID_NO_VMON_BIT = 5;

	// ------------------------------------------------------------
	// Error codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_BAD_SEL = 4'h1;
	localparam logic [3:0] ERR_BAD_MAP = 4'h2;
	localparam logic [FRAC_W-1:0] RST_FRAC = 16'hffff;
	localparam logic [PRI_W-1:0] RST_PRI = 4'h0;
	localparam logic [INT_ID_W-1:0] DEFAULT_ID = 2'h0;

	// Bandwidth preference classes
	typedef enum logic [1:0] {
		PREF_NONE,
		PREF_LOW,
		PREF_MED,
		PREF_HIGH
	} ppn_pref_t;

	// Incoming upstream request
	typedef struct packed {
		logic valid;
		logic ns;
		logic [REQ_ID_W-1:0] id;
		logic [PRI_W-1:0] pri;
		logic [FRAC_W-1:0] usage;
	} ppn_req_t;

	// Request sent downstream
	typedef struct packed {
		logic valid;
		logic ns;
		logic [REQ_ID_W-1:0] id;
		logic [PRI_W-1:0] pri;
	} ppn_dn_t;

	// Response passing upstream
	typedef struct packed {
		logic valid;
		logic [PRI_W-1:0] pri;
	} ppn_rsp_t;

	// Per-partition control settings
	typedef struct packed {
		logic [FRAC_W-1:0] bw_max;
		logic [FRAC_W-1:0] bw_min;
		logic hard_limit;
		logic stride_en;
		logic [STRIDE_W-1:0] stride_minus_one;
		logic [PRI_W-1:0] int_pri;
		logic [PRI_W-1:0] dn_pri;
	} ppn_cfg_t;

endpackage

//--- verif/ppn_far_model.sv
// Far side model: downstream interconnect answering requests
`timescale 1ns/10ps

module ppn_far_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire ppn_pkg::ppn_dn_t dn_i,
	output ppn_pkg::ppn_rsp_t rsp_o
);
	import ppn_pkg::*;

	logic [2:0] wait_ff;
	logic [3:0] lfsr_ff;

	// ----------------------------------------------------------------
	// Response generation
	// ----------------------------------------------------------------
	// Answer after one cycle, or four when slow; idle lines invert
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_ff <= 3'h0;
			lfsr_ff <= 4'h9;
			rsp_o <= '0;
		end else begin
			lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
			if (wait_ff == 3'h1) begin
				rsp_o.valid <= 1'b1;
				rsp_o.pri <= lfsr_ff; // Any nonzero priority may come back
			end else begin
				rsp_o.valid <= 1'b0;
				rsp_o.pri <= ~rsp_o.pri; // Released line, no stale value
			end
			if (wait_ff != 3'h0) begin
				wait_ff <= wait_ff - 3'h1;
			end else if (dn_i.valid) begin
				wait_ff <= slow_i ? 3'h4 : 3'h1;
			end
		end
	end

endmodule // ppn_far_model

//--- verif/tb_top.sv
// Testbench: register, priority, narrowing and arbitration checks
`timescale 1ns/10ps

module tb_top;
	import ppn_pkg::*;

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [DATA_W-1:0] rdata_o, rdata2, rdata3;
	ppn_req_t req_a_i = '0;
	ppn_req_t req_b_i = '0;
	ppn_dn_t dn_o, dn2;
	logic [PRI_W-1:0] int_pri_o;
	logic grant_b_o, stride_active_o, slow, rsp_on = 1'b0;
	ppn_rsp_t rsp_dn_i, rsp_up_o, exp_rsp;
	int err_total = 0;
	int compares = 0;
	ppn_req_t ra, rb;

	// ----------------------------------------------------------------
	// Clock, instances and far side
	// ----------------------------------------------------------------
	always #12.5 clk_i = ~clk_i;

	ppn_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.req_a_i(req_a_i), .req_b_i(req_b_i), .dn_o(dn_o),
		.int_pri_o(int_pri_o), .grant_b_o(grant_b_o),
		.stride_active_o(stride_active_o), .rsp_dn_i(rsp_dn_i),
		.rsp_up_o(rsp_up_o));

	// Variant without internal or downstream priority controls
	ppn_ctrl #(.HAS_INT_PRI(1'b0), .HAS_DN_PRI(1'b0)) dut2 (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata2), .req_a_i(req_a_i),
		.req_b_i(req_b_i), .dn_o(dn2), .int_pri_o(), .grant_b_o(),
		.stride_active_o(), .rsp_dn_i(rsp_dn_i), .rsp_up_o());

	// Variant without narrowing or priority controls, twelve-bit fractions
	ppn_ctrl #(.HAS_NARROW(1'b0), .HAS_INT_PRI(1'b0), .HAS_DN_PRI(1'b0),
		.FRAC_IMPL(12)) dut3 (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata3), .req_a_i(req_a_i), .req_b_i(req_b_i), .dn_o(),
		.int_pri_o(), .grant_b_o(), .stride_active_o(),
		.rsp_dn_i(rsp_dn_i), .rsp_up_o());

	ppn_far_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
		.dn_i(dn_o), .rsp_o(rsp_dn_i));

	// ----------------------------------------------------------------
	// Compare, bus and request tasks
	// ----------------------------------------------------------------
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_dn(input ppn_dn_t got, input ppn_dn_t exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic ppn_dn_t exp_dn(input ppn_req_t r,
		input logic [PRI_W-1:0] p);
		exp_dn = {1'b1, r.ns, r.id, p};
	endfunction

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read, compare the dut and optionally the variant as well
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input bit both);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		cmp32(rdata_o, e);
		if (both) begin
			cmp32(rdata2, e);
		end
	endtask

	// Write then read back with no gap, both narrowing variants
	task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		cmp32(rdata_o, e);
		cmp32(rdata2, e);
	endtask

	task automatic drv(input ppn_req_t a, input ppn_req_t b);
		@(posedge clk_i);
		req_a_i <= a;
		req_b_i <= b;
		@(posedge clk_i);
		#1;
	endtask

	task automatic cmp_arb(input logic g, input logic [3:0] p, input logic s);
		cmp32({26'h0, grant_b_o, stride_active_o, int_pri_o},
			{26'h0, g, s, p});
	endtask

	task automatic end_test(input string name);
		$display("test %s done, compares %0d", name, compares);
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Background response check and watchdog
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		exp_rsp <= rsp_dn_i;
	end

	// Responses pass upstream one cycle later unchanged
	always @(negedge clk_i) begin
		if (rsp_on && exp_rsp.valid) begin
			cmp32({27'h0, rsp_up_o}, {27'h0, exp_rsp});
		end
	end

	initial begin
		#(25 * 20000);
		err_total++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(46));
		slow = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rsp_on <= 1'b1;
		// Identification and status after reset
		rd(OFS_FEATURE_ID, 32'h0000_0037, 0);
		cmp32(rdata2, 32'h0000_0031);
		cmp32(rdata3, 32'h0000_0030);
		rd(OFS_VENDOR_FEAT, 32'h0, 1);
		rd(OFS_ERROR_STATUS, 32'h0, 1);
		end_test("ident");
		// Default partition in both spaces grants full use
		for (int ns = 0; ns < 2; ns++) begin
			wr(OFS_PART_SEL, 32'h0002_0000 | (ns << 16));
			rd(OFS_BW_MAX, 32'h0000_ffff, 1);
			rd(OFS_BW_MIN, 32'h0000_ffff, 1);
			rd(OFS_BW_STRIDE, 32'h0, 1);
			rd(OFS_PRI, 32'h0, 0);
		end
		end_test("reset values");
		// Mapping written through a request selector only
		wr(OFS_PART_SEL, 32'h0000_0005);
		wr_rd(OFS_NARROW_MAP, 32'h8000_0002, 32'h8000_0002);
		wr(OFS_PART_SEL, 32'h0002_0005);
		wr(OFS_NARROW_MAP, 32'h8000_0001);
		wr(OFS_PART_SEL, 32'h0000_0005);
		rd(OFS_NARROW_MAP, 32'h8000_0002, 1);
		wr(OFS_PART_SEL, 32'h0002_0002);
		wr(OFS_BW_MAX, 32'h8000_1234);
		rd(OFS_BW_MAX, 32'h8000_1234, 1);
		wr(OFS_BW_MIN, 32'h0000_8000);
		wr(OFS_BW_MAX, 32'h0000_ffff);
		wr(OFS_BW_STRIDE, 32'h8000_ffff);
		wr(OFS_PRI, 32'h0000_0a05);
		rd(OFS_PRI, 32'h0000_0a05, 0);
		end_test("mapping");
		// Without narrowing the selector is a request id, bit clear
		wr(OFS_PART_SEL, 32'h0000_0001);
		wr(OFS_BW_MAX, 32'h0000_1234);
		wr(OFS_BW_STRIDE, 32'h8000_0003);
		rd(OFS_BW_MAX, 32'h0, 1);
		cmp32(rdata3, 32'h0000_1230);
		rd(OFS_BW_STRIDE, 32'h0, 1);
		cmp32(rdata3, 32'h8000_0003);
		wr(OFS_PART_SEL, 32'h0002_0000);
		rd(OFS_BW_MAX, 32'h0000_ffff, 1);
		cmp32(rdata3, 32'h0);
		end_test("no narrowing");
		// Out of range internal selector is refused and reported
		wr(OFS_PART_SEL, 32'h0002_0007);
		wr(OFS_BW_MAX, 32'h0000_1111);
		rd(OFS_BW_MAX, 32'h0, 1);
		rd(OFS_ERROR_STATUS, 32'h0100_0000, 1);
		wr(OFS_ERROR_STATUS, 32'h0);
		rd(OFS_ERROR_STATUS, 32'h0, 1);
		end_test("bad selector");
		// Random traffic through the narrowed partition
		rb = '0;
		for (int i = 0; i < 24; i++) begin
			ra = {1'b1, 1'b0, 4'h5, 4'($urandom), 16'($urandom_range(0, 16'h7fff))};
			slow <= 1'($urandom);
			drv(ra, rb);
			cmp_dn(dn_o, exp_dn(ra, 4'ha));
			cmp_dn(dn2, exp_dn(ra, ra.pri));
			cmp_arb(1'b0, 4'h5, 1'b1);
		end
		ra = {1'b1, 1'b1, 4'h0, 4'h6, 16'h0};
		drv(ra, rb);
		cmp_dn(dn_o, exp_dn(ra, 4'h0));
		end_test("traffic");
		// Arbitration by preference, then internal priority
		rb = {1'b1, 1'b0, 4'h0, 4'h7, 16'h0};
		ra = {1'b1, 1'b0, 4'h5, 4'h1, 16'h0100};
		drv(ra, rb);
		cmp_arb(1'b0, 4'h5, 1'b1);
		ra.usage = 16'h9000;
		drv(ra, rb);
		cmp_arb(1'b1, 4'h0, 1'b0);
		wr(OFS_PART_SEL, 32'h0002_0002);
		wr(OFS_BW_STRIDE, 32'h0000_0003);
		ra.usage = 16'h0100;
		drv(ra, rb);
		cmp_arb(1'b0, 4'h5, 1'b0);
		wr(OFS_PRI, 32'h0000_0a00);
		drv(ra, rb);
		cmp_arb(1'b0, 4'h0, 1'b0);
		end_test("arbitration");
		// Hard limit over maximum stops the partition
		wr(OFS_BW_MAX, 32'h8000_1000);
		wr(OFS_BW_MIN, 32'h0000_0800);
		rb = '0;
		ra.usage = 16'h2000;
		drv(ra, rb);
		cmp32({31'h0, dn_o.valid}, 32'h0);
		wr(OFS_BW_MAX, 32'h0000_1000);
		drv(ra, rb);
		cmp_dn(dn_o, exp_dn(ra, 4'ha));
		end_test("limits");
		// Invalid mapping blocks traffic and is reported
		wr(OFS_PART_SEL, 32'h0000_0009);
		wr(OFS_NARROW_MAP, 32'h0000_0000);
		ra = {1'b1, 1'b0, 4'h9, 4'h2, 16'h0};
		drv(ra, rb);
		cmp32({31'h0, dn_o.valid}, 32'h0);
		rd(OFS_ERROR_STATUS, 32'h0200_0000, 1);
		drv('0, rb);
		wr(OFS_ERROR_STATUS, 32'h0);
		rd(OFS_ERROR_STATUS, 32'h0, 1);
		end_test("bad map");
		repeat (6) @(posedge clk_i);
		finish_test;
	end

endmodule // tb_top
